// ### inc/ocm_params.svh
// Register offsets, field positions, reset values of the compare mode block.
`ifndef OCM_PARAMS_SVH
`define OCM_PARAMS_SVH
`define OCM_MODE_OFS 8'h18
`define OCM_CHEN_OFS 8'h20
`define OCM_PROT_OFS 8'h24
`define OCM_CMP1_OFS 8'h34
`define OCM_CMP2_OFS 8'h38
`define OCM_STAT_OFS 8'h40
`define OCM_MODE_RST 16'h0000
`define OCM_CH_STRIDE 8
`define OCM_DIR_LSB 0
`define OCM_FEN_BIT 2
`define OCM_PEN_BIT 3
`define OCM_MOD_LSB 4
`define OCM_CEN_BIT 7
`define OCM_PROT_LOCK 2'h3
`endif

// ### inc/ocm_pkg.sv
// Types shared by the output-compare mode configuration block.
package ocm_pkg;
    typedef enum logic [2:0] {
        MODE_FREEZE = 3'h0,
        MODE_SET = 3'h1,
        MODE_CLEAR = 3'h2,
        MODE_TOGGLE = 3'h3,
        MODE_FORCE_LOW = 3'h4,
        MODE_FORCE_HIGH = 3'h5,
        MODE_PWM_ONE = 3'h6,
        MODE_PWM_TWO = 3'h7
    } compare_mode_t;
    typedef enum logic [1:0] {
        DIR_OUTPUT = 2'h0,
        DIR_OWN_INPUT = 2'h1,
        DIR_OTHER_INPUT = 2'h2,
        DIR_TRIGGER = 2'h3
    } direction_t;
endpackage

// ### rtl/output_compare_mode_config.sv
// Output-compare mode register and reference generation for channels 1, 2.
//
// Contract
// [R1] Ch1 direction 00 output, 01 input one, 10 input two, 11 trigger.
// [R2] Ch1 direction field only written while ch1 enable is clear.
// [R3] Fast enable lets a trigger event act on the reference at once.
// [R4] Preload off: compare value write is used for comparison immediately.
// [R5] Preload on: compare value waits in a shadow until update event.
// [R6] Protection level 3 and output: preload and mode writes ignored.
// [R7] Software uses unpreloaded PWM only in single-pulse mode.
// [R8] Mode 000: compare match leaves the reference unchanged.
// [R9] Mode 001: reference goes high when counter equals compare.
// [R10] Mode 010: reference goes low when counter equals compare.
// [R11] Mode 011: reference toggles when counter equals compare.
// [R12] Mode 100 holds reference low, mode 101 holds it high.
// [R13] Mode 110: high while counter below compare, else low.
// [R14] Mode 111: high while counter above compare, else low.
// [R15] PWM reference moves only on compare change or freeze-to-PWM.
// [R16] Clear enable set: high filtered trigger forces reference to 0.
// [R17] Ch2 direction 00 output, 01 input two, 10 input one, 11 trigger.
// [R18] Ch2 direction field only written while ch2 enable is clear.
// [R19] Ch2 fast, preload, mode, clear controls at bits 10,11,14:12,15.
// [R20] Mode register at offset 0x18, reset value all zeros.
// [R21] Trigger-cleared reference stays cleared until next update event.
`include "ocm_params.svh"
module output_compare_mode_config
    import ocm_pkg::*;
#(
    parameter int CMP_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire logic [CMP_W-1:0] i_counter_value,
    input wire logic i_update_event,
    input wire logic i_trigger_event,
    input wire logic i_filtered_external_trigger,
    input wire logic i_timer_input_one,
    input wire logic i_timer_input_two,
    input wire logic i_internal_trigger_source,
    output logic o_ch1_output_reference,
    output logic o_ch2_output_reference,
    output logic o_ch1_capture_input,
    output logic o_ch2_capture_input
);

    logic ack;
    logic [31:0] rdata;
    logic [15:0] mode_reg;
    logic [1:0] ch_enable;
    logic [1:0] prot_level;
    logic [CMP_W-1:0] preload_cmp [2];
    logic [CMP_W-1:0] active_cmp [2];
    logic [1:0] ref_q;
    logic [1:0] prev_level;
    logic [1:0] cleared;
    logic [1:0] released;
    logic [2:0] prev_mode [2];
    logic cap1;
    logic cap2;

    // Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are unused.
    function automatic logic [15:0] merge_sel(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Drops the parts of a mode write that the channel state locks.
    function automatic logic [15:0] guard_mode(input logic [15:0] old,
                                               input logic [15:0] nw,
                                               input logic [1:0] en,
                                               input logic [1:0] prot);
        logic [15:0] res;
        int b;
        res = nw;
        for (int c = 0; c < 2; c++) begin
            b = c * `OCM_CH_STRIDE;
            if (en[c]) begin
                res[b+`OCM_DIR_LSB +: 2] = old[b+`OCM_DIR_LSB +: 2]; // [R2] [R18]
            end
            if (prot == `OCM_PROT_LOCK &&
                old[b+`OCM_DIR_LSB +: 2] == DIR_OUTPUT) begin
                res[b+`OCM_PEN_BIT] = old[b+`OCM_PEN_BIT]; // [R6]
                res[b+`OCM_MOD_LSB +: 3] = old[b+`OCM_MOD_LSB +: 3]; // [R6]
            end
        end
        return res;
    endfunction

    function automatic logic pick_input(input logic [1:0] dir,
                                        input logic own,
                                        input logic other,
                                        input logic internal_trigger_source);
        logic res;
        res = 1'b0;
        case (dir)
            DIR_OWN_INPUT: res = own;
            DIR_OTHER_INPUT: res = other;
            DIR_TRIGGER: res = internal_trigger_source;
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    function automatic logic [CMP_W-1:0] merge_cmp(input logic [CMP_W-1:0] o,
                                                   input logic [31:0] wd,
                                                   input logic [3:0] sel);
        logic [15:0] m;
        m = merge_sel(16'(o), wd, sel);
        return CMP_W'(m);
    endfunction

    logic req;
    logic wr_acc;
    assign req = i_wb_cyc & i_wb_stb;
    // The write lands on the edge where the master sees ack.
    assign wr_acc = req & i_wb_we & ack;

    always_comb begin
        rdata = 32'h0000_0000;
        if (i_wb_adr == `OCM_MODE_OFS) begin
            rdata[15:0] = mode_reg;
        end else if (i_wb_adr == `OCM_CHEN_OFS) begin
            rdata[1:0] = ch_enable;
        end else if (i_wb_adr == `OCM_PROT_OFS) begin
            rdata[1:0] = prot_level;
        end else if (i_wb_adr == `OCM_CMP1_OFS) begin
            rdata[CMP_W-1:0] = preload_cmp[0];
        end else if (i_wb_adr == `OCM_CMP2_OFS) begin
            rdata[CMP_W-1:0] = preload_cmp[1];
        end else if (i_wb_adr == `OCM_STAT_OFS) begin
            rdata[3:0] = {cleared, ref_q};
        end
    end

    // Unmapped addresses are acknowledged and read as zero.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            ack <= req & ~ack;
            if (req & ~ack) begin
                o_wb_dat <= rdata;
            end
        end
    end
    assign o_wb_ack = ack;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_reg <= `OCM_MODE_RST; // [R20]
            ch_enable <= 2'h0;
            prot_level <= 2'h0;
        end else if (wr_acc) begin
            if (i_wb_adr == `OCM_MODE_OFS) begin
                mode_reg <= guard_mode(mode_reg,
                    merge_sel(mode_reg, i_wb_dat, i_wb_sel),
                    ch_enable, prot_level); // [R19]
            end else if (i_wb_adr == `OCM_CHEN_OFS && i_wb_sel[0]) begin
                ch_enable <= i_wb_dat[1:0];
            end else if (i_wb_adr == `OCM_PROT_OFS && i_wb_sel[0]) begin
                prot_level <= i_wb_dat[1:0];
            end
        end
    end

    // Compare values: shadow written by software, active used by match.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int c = 0; c < 2; c++) begin
                preload_cmp[c] <= '0;
                active_cmp[c] <= '0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_acc && i_wb_adr == (c == 0 ? `OCM_CMP1_OFS
                                                  : `OCM_CMP2_OFS)) begin
                    preload_cmp[c] <= merge_cmp(preload_cmp[c], i_wb_dat,
                                                i_wb_sel);
                    if (!mode_reg[c*`OCM_CH_STRIDE+`OCM_PEN_BIT]) begin
                        active_cmp[c] <= merge_cmp(preload_cmp[c], i_wb_dat,
                                                   i_wb_sel); // [R4]
                    end else if (i_update_event) begin
                        active_cmp[c] <= preload_cmp[c]; // [R5]
                    end
                end else if (i_update_event ||
                             !mode_reg[c*`OCM_CH_STRIDE+`OCM_PEN_BIT]) begin
                    active_cmp[c] <= preload_cmp[c]; // [R5]
                end
            end
        end
    end

    // Capture input routing; a channel set as output drives zero here.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cap1 <= 1'b0;
            cap2 <= 1'b0;
        end else begin
            cap1 <= pick_input(mode_reg[1:0], i_timer_input_one,
                               i_timer_input_two,
                               i_internal_trigger_source); // [R1]
            cap2 <= pick_input(mode_reg[9:8], i_timer_input_two,
                               i_timer_input_one,
                               i_internal_trigger_source); // [R17]
        end
    end
    assign o_ch1_capture_input = cap1;
    assign o_ch2_capture_input = cap2;

    logic [1:0] clr_now;
    logic [1:0] match;
    logic [1:0] fast_hit;
    logic [1:0] level;
    compare_mode_t mode [2];

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            mode[c] = compare_mode_t'(mode_reg[c*`OCM_CH_STRIDE+`OCM_MOD_LSB
                                               +: 3]);
            clr_now[c] = mode_reg[c*`OCM_CH_STRIDE+`OCM_CEN_BIT] &
                         i_filtered_external_trigger; // [R16]
            match[c] = i_counter_value == active_cmp[c];
            fast_hit[c] = mode_reg[c*`OCM_CH_STRIDE+`OCM_FEN_BIT] &
                          i_trigger_event; // [R3]
            level[c] = (mode[c] == MODE_PWM_TWO)
                ? i_counter_value > active_cmp[c] // [R14]
                : i_counter_value < active_cmp[c]; // [R13]
        end
    end

    // The clear holds until an update; a trigger in that cycle still wins.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cleared <= 2'h0;
            released <= 2'h0;
        end else begin
            cleared <= clr_now | (cleared & ~{2{i_update_event}}); // [R21]
            released <= cleared & {2{i_update_event}} & ~clr_now;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_level <= 2'h0;
            prev_mode[0] <= MODE_FREEZE;
            prev_mode[1] <= MODE_FREEZE;
        end else begin
            prev_level <= level;
            prev_mode[0] <= mode[0];
            prev_mode[1] <= mode[1];
        end
    end

    // A fast PWM trigger jumps to a fresh period's level, skipping the compare.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ref_q <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (clr_now[c] || cleared[c]) begin
                    ref_q[c] <= 1'b0; // [R16] [R21]
                end else begin
                    case (mode[c])
                        MODE_FREEZE: ref_q[c] <= ref_q[c]; // [R8]
                        MODE_SET: begin
                            if (match[c] || fast_hit[c]) begin
                                ref_q[c] <= 1'b1; // [R9]
                            end
                        end
                        MODE_CLEAR: begin
                            if (match[c] || fast_hit[c]) begin
                                ref_q[c] <= 1'b0; // [R10]
                            end
                        end
                        MODE_TOGGLE: begin
                            if (match[c] || fast_hit[c]) begin
                                ref_q[c] <= ~ref_q[c]; // [R11]
                            end
                        end
                        MODE_FORCE_LOW: ref_q[c] <= 1'b0; // [R12]
                        MODE_FORCE_HIGH: ref_q[c] <= 1'b1; // [R12]
                        default: begin
                            if (fast_hit[c]) begin
                                ref_q[c] <= mode[c] == MODE_PWM_ONE; // [R3]
                            end else if (level[c] != prev_level[c] ||
                                         prev_mode[c] == MODE_FREEZE ||
                                         released[c]) begin
                                ref_q[c] <= level[c]; // [R15]
                            end
                        end
                    endcase
                end
            end
        end
    end
    assign o_ch1_output_reference = ref_q[0];
    assign o_ch2_output_reference = ref_q[1];

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic wr_mode;
    assign wr_mode = wr_acc && i_wb_adr == `OCM_MODE_OFS;

    property p_dir1_lock;
        wr_mode && ch_enable[0] |=> mode_reg[1:0] == $past(mode_reg[1:0]);
    endproperty
    a_dir1_lock: assert property (p_dir1_lock) // [R2]
        else $error("ch1 direction changed while enabled");

    property p_dir2_lock;
        wr_mode && ch_enable[1] |=> mode_reg[9:8] == $past(mode_reg[9:8]);
    endproperty
    a_dir2_lock: assert property (p_dir2_lock) // [R18]
        else $error("ch2 direction changed while enabled");

    property p_prot_lock;
        wr_mode && prot_level == 2'h3 && mode_reg[1:0] == 2'h0
            |=> mode_reg[6:3] == $past(mode_reg[6:3]);
    endproperty
    a_prot_lock: assert property (p_prot_lock) // [R6]
        else $error("ch1 preload or mode changed under lock");

    property p_freeze;
        mode[0] == MODE_FREEZE && !clr_now[0] && !cleared[0]
            |=> $stable(o_ch1_output_reference);
    endproperty
    a_freeze: assert property (p_freeze) // [R8]
        else $error("reference moved in freeze mode");

    property p_set;
        mode[0] == MODE_SET && match[0] && !clr_now[0] && !cleared[0]
            |=> o_ch1_output_reference;
    endproperty
    a_set: assert property (p_set) // [R9]
        else $error("reference not set on match");

    property p_toggle;
        mode[0] == MODE_TOGGLE && match[0] && !clr_now[0] && !cleared[0]
            |=> o_ch1_output_reference != $past(o_ch1_output_reference);
    endproperty
    a_toggle: assert property (p_toggle) // [R11]
        else $error("reference not toggled on match");

    property p_force_low;
        mode[0] == MODE_FORCE_LOW |=> !o_ch1_output_reference;
    endproperty
    a_force_low: assert property (p_force_low) // [R12]
        else $error("forced low not low");

    property p_no_preload;
        wr_acc && i_wb_adr == `OCM_CMP1_OFS && i_wb_sel[1:0] == 2'h3 &&
            !mode_reg[3] |=> active_cmp[0] == $past(i_wb_dat[CMP_W-1:0]);
    endproperty
    a_no_preload: assert property (p_no_preload) // [R4]
        else $error("compare write not immediate");

    property p_preload;
        mode_reg[3] && !i_update_event |=> $stable(active_cmp[0]);
    endproperty
    a_preload: assert property (p_preload) // [R5]
        else $error("active compare moved without update");

    property p_clear_hold;
        clr_now[0] ##1 !i_update_event [*2] |-> !o_ch1_output_reference;
    endproperty
    a_clear_hold: assert property (p_clear_hold) // [R21]
        else $error("cleared reference came back before update");

    property p_pwm_steady;
        mode[0] == MODE_PWM_ONE && prev_mode[0] == MODE_PWM_ONE &&
            level[0] == prev_level[0] && !fast_hit[0] && !released[0] &&
            !clr_now[0] && !cleared[0] |=> $stable(o_ch1_output_reference);
    endproperty
    a_pwm_steady: assert property (p_pwm_steady) // [R15]
        else $error("PWM reference moved without compare change");

    c_pwm_run: cover property (mode[0] == MODE_PWM_ONE && match[0]);
    c_clear_release: cover property (released[0]);
    c_dir_block: cover property (wr_mode && ch_enable[0]);
endmodule

// ### testbench/output_compare_mode_config_bench.sv
// Self-checking bench for the output-compare mode configuration block.
`include "ocm_params.svh"
module output_compare_mode_config_bench
    import ocm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    typedef struct {compare_mode_t p; compare_mode_t m; logic e;} mrow_t;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [15:0] cnt = 16'h0100;
    logic upd = 1'h0;
    logic trg = 1'h0;
    logic etr = 1'h0;
    logic tin1 = 1'h0;
    logic tin2 = 1'h0;
    logic internal_trigger_source = 1'h0;
    logic ack, ref1, ref2, cap1, cap2;
    logic [31:0] rdat;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    // Status and unmapped rows come last so no earlier write moves a ref.
    row_t rows [10] = '{
        '{8'h18, 32'hffff_8f8f, 32'h0000_8f8f},
        '{8'h18, 32'h0000_0000, 32'h0000_0000},
        '{8'h34, 32'h1234_a5c3, 32'h0000_a5c3},
        '{8'h38, 32'h0000_3c5a, 32'h0000_3c5a},
        '{8'h20, 32'h0000_0003, 32'h0000_0003},
        '{8'h20, 32'h0000_0000, 32'h0000_0000},
        '{8'h24, 32'h0000_0003, 32'h0000_0003},
        '{8'h24, 32'h0000_0000, 32'h0000_0000},
        '{8'h50, 32'h0000_ffff, 32'h0000_0000},
        '{8'h40, 32'h0000_00ff, 32'h0000_0000}};
    mrow_t mrows [8] = '{
        '{MODE_FORCE_LOW, MODE_FREEZE, 1'h0},
        '{MODE_FORCE_HIGH, MODE_FREEZE, 1'h1},
        '{MODE_FORCE_LOW, MODE_SET, 1'h1},
        '{MODE_FORCE_HIGH, MODE_CLEAR, 1'h0},
        '{MODE_FORCE_LOW, MODE_TOGGLE, 1'h1},
        '{MODE_FORCE_HIGH, MODE_TOGGLE, 1'h0},
        '{MODE_FORCE_HIGH, MODE_FORCE_LOW, 1'h0},
        '{MODE_FORCE_LOW, MODE_FORCE_HIGH, 1'h1}};
    logic [7:0] reg_ofs [6] = '{8'h18, 8'h20, 8'h24, 8'h34, 8'h38, 8'h40};

    output_compare_mode_config #(.CMP_W(16), .ADDR_W(8)) dut (
        .i_clk(clk), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_counter_value(cnt),
        .i_update_event(upd), .i_trigger_event(trg),
        .i_filtered_external_trigger(etr), .i_timer_input_one(tin1),
        .i_timer_input_two(tin2), .i_internal_trigger_source(internal_trigger_source),
        .o_ch1_output_reference(ref1), .o_ch2_output_reference(ref2),
        .o_ch1_capture_input(cap1), .o_ch2_capture_input(cap2));

    always #25 clk = ~clk;

    task automatic test_done();
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles; this ceiling leaves slack.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("[ERR] run_time expected done seen running");
            test_done();
        end
    end

    task automatic chk_reg(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Classic single cycle: request held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h3;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        chk_bit("wb_ack", 1'h1, ack);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, q);
        chk_reg(nm, e, q);
    endtask

    function automatic logic [7:0] mv(input logic c, input compare_mode_t m,
        input logic p, input logic f);
        return {c, m, p, f, 2'h0};
    endfunction

    task automatic set1(input logic [7:0] c1);
        wr(`OCM_MODE_OFS, {24'h0, c1});
        tick(2);
    endtask

    task automatic level(input logic [15:0] v);
        @(posedge clk);
        cnt <= v;
        tick(3);
    endtask

    task automatic hit(input logic [15:0] v);
        @(posedge clk);
        cnt <= v;
        @(posedge clk);
        cnt <= 16'h0100;
        tick(3);
    endtask

    // Kind 0 is the external trigger, 1 the update, 2 the trigger event.
    task automatic evt(input int k);
        @(posedge clk);
        etr <= (k == 0);
        upd <= (k == 1);
        trg <= (k == 2);
        @(posedge clk);
        etr <= 1'h0;
        upd <= 1'h0;
        trg <= 1'h0;
        tick(3);
    endtask

    initial begin
        tick(10);
        chk_bit("ref1 in reset", 1'h0, ref1);
        chk_bit("ack in reset", 1'h0, ack);
        tick(10);
        resetn <= 1'h1;
        foreach (reg_ofs[i]) begin
            rd_chk("reset value", reg_ofs[i], 32'h0);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd_chk("reg row", rows[i].a, rows[i].e);
        end
        wr(`OCM_CHEN_OFS, 32'h3);
        wr(`OCM_MODE_OFS, 32'h0303);
        rd_chk("dir locked", `OCM_MODE_OFS, 32'h0);
        wr(`OCM_CHEN_OFS, 32'h0);
        for (int d = 1; d < 4; d++) begin
            wr(`OCM_MODE_OFS, {22'h0, d[1:0], 6'h0, d[1:0]});
            for (int s = 0; s < 3; s++) begin
                @(posedge clk);
                tin1 <= (s == 0);
                tin2 <= (s == 1);
                internal_trigger_source <= (s == 2);
                tick(3);
                chk_bit("cap1", d == s + 1, cap1);
                chk_bit("cap2", (d == 3) ? s == 2 : d + s == 2, cap2);
            end
        end
        set1(8'h00);
        chk_bit("cap1 output dir", 1'h0, cap1);
        wr(`OCM_CMP1_OFS, 32'h5);
        foreach (mrows[i]) begin
            set1(mv(1'h0, mrows[i].p, 1'h0, 1'h0));
            set1(mv(1'h0, mrows[i].m, 1'h0, 1'h0));
            hit(16'h0005);
            chk_bit("mode", mrows[i].e, ref1);
        end
        set1(mv(1'h0, MODE_FORCE_LOW, 1'h0, 1'h0));
        set1(mv(1'h0, MODE_FREEZE, 1'h0, 1'h0));
        level(16'h0002);
        set1(mv(1'h0, MODE_PWM_ONE, 1'h1, 1'h0));
        chk_bit("pwm1 below", 1'h1, ref1);
        level(16'h0005);
        chk_bit("pwm1 equal", 1'h0, ref1);
        level(16'h0002);
        set1(mv(1'h0, MODE_FORCE_LOW, 1'h0, 1'h0));
        set1(mv(1'h0, MODE_PWM_ONE, 1'h1, 1'h0));
        chk_bit("pwm1 kept", 1'h0, ref1);
        level(16'h0007);
        level(16'h0002);
        chk_bit("pwm1 crossed", 1'h1, ref1);
        set1(mv(1'h0, MODE_FREEZE, 1'h0, 1'h0));
        level(16'h0007);
        set1(mv(1'h0, MODE_PWM_TWO, 1'h1, 1'h0));
        chk_bit("pwm2 above", 1'h1, ref1);
        level(16'h0005);
        chk_bit("pwm2 equal", 1'h0, ref1);
        level(16'h0006);
        set1(mv(1'h1, MODE_PWM_TWO, 1'h1, 1'h0));
        evt(0);
        chk_bit("ref1 cleared", 1'h0, ref1);
        rd_chk("status cleared", `OCM_STAT_OFS, 32'h4);
        tick(10);
        chk_bit("ref1 held clear", 1'h0, ref1);
        evt(1);
        chk_bit("ref1 resumed", 1'h1, ref1);
        set1(mv(1'h0, MODE_PWM_TWO, 1'h1, 1'h0));
        evt(0);
        chk_bit("clear disabled", 1'h1, ref1);
        level(16'h0100);
        set1(mv(1'h0, MODE_FORCE_LOW, 1'h0, 1'h0));
        set1(mv(1'h0, MODE_SET, 1'h0, 1'h0));
        evt(2);
        chk_bit("slow trigger", 1'h0, ref1);
        set1(mv(1'h0, MODE_SET, 1'h0, 1'h1));
        evt(2);
        chk_bit("fast trigger", 1'h1, ref1);
        wr(`OCM_PROT_OFS, 32'h3);
        wr(`OCM_MODE_OFS, 32'h00e8);
        rd_chk("locked mode", `OCM_MODE_OFS, 32'h0090);
        wr(`OCM_PROT_OFS, 32'h0);
        set1(mv(1'h0, MODE_FORCE_LOW, 1'h0, 1'h0));
        set1(mv(1'h0, MODE_SET, 1'h0, 1'h0));
        wr(`OCM_CMP1_OFS, 32'h9);
        hit(16'h0009);
        chk_bit("direct compare", 1'h1, ref1);
        set1(mv(1'h0, MODE_FORCE_LOW, 1'h0, 1'h0));
        set1(mv(1'h0, MODE_SET, 1'h1, 1'h0));
        wr(`OCM_CMP1_OFS, 32'hc);
        hit(16'h000c);
        chk_bit("shadow held", 1'h0, ref1);
        rd_chk("shadow value", `OCM_CMP1_OFS, 32'hc);
        hit(16'h0009);
        chk_bit("old compare", 1'h1, ref1);
        set1(mv(1'h0, MODE_FORCE_LOW, 1'h0, 1'h0));
        set1(mv(1'h0, MODE_SET, 1'h1, 1'h0));
        evt(1);
        hit(16'h000c);
        chk_bit("shadow applied", 1'h1, ref1);
        wr(`OCM_CMP2_OFS, 32'h3);
        wr(`OCM_MODE_OFS, {16'h0, mv(1'h0, MODE_FORCE_LOW, 1'h0, 1'h0), 8'h0});
        wr(`OCM_MODE_OFS, {16'h0, mv(1'h0, MODE_TOGGLE, 1'h0, 1'h0), 8'h0});
        hit(16'h0003);
        chk_bit("ref2 toggle", 1'h1, ref2);
        test_done();
    end
endmodule
